// ### design/drcs_pkg.sv
/*
 Shared constants and types of the ring driver controller: register map,
 field positions, descriptor flags, layout figures and the sequencer states.
 Assumes a single clock domain and a 32-bit software register port.
*/
package drcs_pkg;

   // Register byte offsets on the software port.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_QSIZE = 8'h04;
   localparam logic [7:0] REG_DESC = 8'h08;
   localparam logic [7:0] REG_AVAIL = 8'h0c;
   localparam logic [7:0] REG_USED = 8'h10;
   localparam logic [7:0] REG_SEGA = 8'h14;
   localparam logic [7:0] REG_SEGL = 8'h18;
   localparam logic [7:0] REG_SEGP = 8'h1c;
   localparam logic [7:0] REG_CFGO = 8'h20;
   localparam logic [7:0] REG_CFGS = 8'h24;
   localparam logic [7:0] REG_FEAT = 8'h28;
   localparam logic [7:0] REG_CFG0 = 8'h2c;
   localparam logic [7:0] REG_CFG1 = 8'h30;
   localparam logic [7:0] REG_STAT = 8'h34;
   localparam logic [7:0] REG_UID = 8'h38;
   localparam logic [7:0] REG_ULEN = 8'h3c;

   // Control bits; all but the legacy bit are one-shot commands.
   localparam int CTRL_LEGACY = 0;
   localparam int CTRL_SUBMIT = 1;
   localparam int CTRL_CFGRD = 2;
   localparam int CTRL_POLL = 3;
   localparam int CTRL_CLRERR = 4;

   // Config request word fields.
   localparam int CFGO_WIDE = 16;
   localparam int CFGO_FLSB = 24;
   localparam int CFGO_OPT = 31;

   // Status error bit positions, counted from bit 1.
   localparam int ERR_QSIZE = 0;
   localparam int ERR_ORDER = 1;
   localparam int ERR_FULL = 2;
   localparam int ERR_FEAT = 3;
   localparam int ERR_CFGSZ = 4;

   // Layout figures.
   localparam logic [16:0] QSIZE_MAX = 17'h08000;
   localparam logic [15:0] QSIZE_RST = 16'h0100;
   localparam logic [31:0] PAGE_MASK = 32'h0000_0fff;
   localparam logic [31:0] ALIGN4_MASK = 32'h0000_0003;
   localparam logic [31:0] RING_HDR = 32'h0000_0006;
   localparam logic [31:0] RING_IDX_OFS = 32'h0000_0002;
   localparam logic [31:0] RING_ENT_OFS = 32'h0000_0004;
   localparam logic [15:0] DESC_F_NEXT = 16'h0001;
   localparam logic [15:0] DESC_F_WRITE = 16'h0002;

   typedef struct packed {
      logic req;
      logic we;
      logic half;
      logic [31:0] addr;
      logic [31:0] wdata;
   } drcs_mem_t;

   typedef struct packed {
      logic rd;
      logic gen;
      logic [15:0] addr;
   } drcs_cfg_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h00, ST_DESC = 5'h01, ST_AVENT = 5'h02, ST_AVIDX = 5'h03,
      ST_NOTE = 5'h04, ST_UIDX = 5'h05, ST_UCHK = 5'h06, ST_UID = 5'h07,
      ST_ULEN = 5'h08, ST_UDONE = 5'h09, ST_CGEN0 = 5'h0a, ST_CD0 = 5'h0b,
      ST_CD1 = 5'h0c, ST_CGEN1 = 5'h0d, ST_CCHK = 5'h0e, ST_MWAIT = 5'h0f,
      ST_CWAIT = 5'h10
   } drcs_state_t;

endpackage

// ### design/drcs_host.sv
/*
 Driver-side controller for a shared-memory descriptor-ring device: it lays
 out one queue, writes descriptor chains and available-ring entries, notifies,
 reaps the used ring and reads device configuration with consistency retries.
 Assumes a shared-memory port that acknowledges each access and a config
 port that acknowledges each read; both are synchronous to clk.
*/
// Notes on behaviour
// RULE_01 - Modern config and ring fields are little-endian.
// RULE_02 - Device bumps generation when config may differ.
// RULE_03 - Reread config until generation samples match.
// RULE_04 - Optional fields need their feature offered.
// RULE_05 - Accept any config size large enough.
// RULE_06 - Config readable before features are accepted.
// RULE_07 - Queue size is a 16-bit entry count.
// RULE_08 - Queue size power of two, at most 32768.
// RULE_09 - Outstanding buffers never exceed queue size.
// RULE_10 - Three contiguous parts: table, available, used.
// RULE_11 - Alignments 16, 2 and 4 bytes.
// RULE_12 - Sizes 16q, 6+2q and 6+4q bytes; the code spaces used ring entries 8 bytes apart.
// RULE_13 - Fill descriptors, post head, then notify.
// RULE_14 - Device posts used head, then interrupts.
// RULE_15 - Device accepts any descriptor split.
// RULE_16 - Writable descriptors follow readable ones.
// RULE_17 - Legacy: used ring starts on next page.
// RULE_18 - Legacy: fields use guest native order.
// RULE_19 - Legacy any-layout: no framing assumptions.
// RULE_20 - Legacy: reread config until two reads agree.
// RULE_21 - Each descriptor entry is 16 bytes.
// RULE_22 - Features-accepted status flag has value 8.
// RULE_23 - Ring addresses follow from table base and size.
`timescale 1ns/10ps
`default_nettype none

module drcs_host #(
   parameter int MAX_SEG = 4,
   parameter int TRK_W = 8,
   parameter logic GUEST_BE = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var logic [31:0] reg_rdata,
   output var drcs_pkg::drcs_mem_t mem,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output var drcs_pkg::drcs_cfg_t cfg,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   output var logic notify,
   input wire logic used_irq
);

   localparam int SW = $clog2(MAX_SEG);

   drcs_pkg::drcs_state_t st_q, ret_q;
   logic legacy_q;
   logic [15:0] qsize_q, qm;
   logic [31:0] desc_q, avail_q, used_q, aend, avail_d, used_d;
   logic [31:0] stage_a_q, stage_l_q, cfgo_q, cfgs_q, feat_q;
   logic [31:0] sega_q [MAX_SEG];
   logic [31:0] segl_q [MAX_SEG];
   logic [MAX_SEG-1:0] segw_q;
   logic [SW:0] nseg_q, k_q;
   logic [1:0] w_q;
   logic [15:0] cur_q, head_q, slot_q, aidx_q, lused_q;
   logic [15:0] out_q, inuse_q;
   logic [7:0] chain_mem [2**TRK_W];
   logic [31:0] rd_q, uid_q, ulen_q, gena_q, genb_q, d0_q, d1_q, p0_q, p1_q;
   logic [31:0] cfg0_q, cfg1_q;
   logic [1:0] csel_q;
   logic have_q, cdone_q, poll_q;
   logic [4:0] err_q, err_set;
   logic cmd, go_sub, go_cfg, go_poll, q_ok, sub_ok, cfg_chk, be;
   logic [31:0] cfg_need;
   logic [15:0] nxt, flg;
   logic [31:0] dword;

   // Byte order toward memory and config: lanes are little-endian, so only a
   // legacy big-endian guest needs swapping, per 16-bit field when h is set.
   function automatic logic [31:0] fix(input logic [31:0] d, input logic h, input logic sw);
      logic [31:0] r;
      r = d;
      if (sw && h) begin
         r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end else if (sw) begin
         r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      end
      return r;
   endfunction

   // Command decode and start checks. Commands arriving while busy are dropped.
   always_comb begin
      be = legacy_q && GUEST_BE; // [RULE_01] [RULE_18]
      qm = qsize_q - 16'h0001;
      q_ok = (qsize_q != 16'h0000) && ((qsize_q & qm) == 16'h0000) &&
             ({1'b0, qsize_q} <= drcs_pkg::QSIZE_MAX); // [RULE_07] [RULE_08]
      cmd = reg_wr && (reg_addr == drcs_pkg::REG_CTRL) && (st_q == drcs_pkg::ST_IDLE);
      go_sub = cmd && reg_wdata[drcs_pkg::CTRL_SUBMIT];
      go_cfg = cmd && reg_wdata[drcs_pkg::CTRL_CFGRD];
      go_poll = (cmd && reg_wdata[drcs_pkg::CTRL_POLL]) || poll_q;
      // Room for one more buffer and for all its descriptors.
      sub_ok = q_ok && (nseg_q != '0) && (out_q < qsize_q) &&
               (16'(nseg_q) <= (qsize_q - inuse_q)); // [RULE_09]
      // A narrower config than needed is an error; a wider one is fine.
      cfg_need = {16'h0000, cfgo_q[15:0]} + (cfgo_q[drcs_pkg::CFGO_WIDE] ? 32'h8 : 32'h4);
      cfg_chk = (cfg_need <= cfgs_q) && // [RULE_05]
                (!cfgo_q[drcs_pkg::CFGO_OPT] || feat_q[cfgo_q[drcs_pkg::CFGO_FLSB+:5]]); // [RULE_04]
      err_set = '0;
      err_set[drcs_pkg::ERR_QSIZE] = go_sub && !q_ok;
      err_set[drcs_pkg::ERR_FULL] = go_sub && q_ok && !sub_ok;
      err_set[drcs_pkg::ERR_FEAT] = go_cfg && !cfg_chk && (cfg_need <= cfgs_q);
      err_set[drcs_pkg::ERR_CFGSZ] = go_cfg && (cfg_need > cfgs_q);
      err_set[drcs_pkg::ERR_ORDER] = reg_wr && (reg_addr == drcs_pkg::REG_SEGP) &&
                                     (nseg_q != '0) && segw_q[SW'(nseg_q - 1'b1)] &&
                                     !reg_wdata[0];
   end

   // Queue layout: table, then available ring, then used ring aligned to 4,
   // or to the next page when the legacy layout is selected.
   always_comb begin
      avail_d = desc_q + {12'h000, qsize_q, 4'h0}; // [RULE_12] [RULE_21] [RULE_23]
      aend = avail_d + drcs_pkg::RING_HDR + {15'h0000, qsize_q, 1'b0}; // [RULE_12]
      if (legacy_q) begin
         used_d = (aend + drcs_pkg::PAGE_MASK) & ~drcs_pkg::PAGE_MASK; // [RULE_17]
      end else begin
         used_d = (aend + drcs_pkg::ALIGN4_MASK) & ~drcs_pkg::ALIGN4_MASK; // [RULE_11]
      end
   end

   // Next descriptor fields: writable flag per segment, next link on all but last.
   always_comb begin
      nxt = (cur_q + 16'h0001) & qm;
      flg = segw_q[k_q[SW-1:0]] ? drcs_pkg::DESC_F_WRITE : 16'h0000;
      if (k_q != nseg_q - 1'b1) begin
         flg = flg | drcs_pkg::DESC_F_NEXT;
      end else begin
         nxt = 16'h0000;
      end
      case (w_q)
         2'd0: dword = be ? 32'h0 : sega_q[k_q[SW-1:0]];
         2'd1: dword = be ? sega_q[k_q[SW-1:0]] : 32'h0;
         2'd2: dword = segl_q[k_q[SW-1:0]];
         default: dword = {nxt, flg};
      endcase
   end

   // Software-written configuration and derived ring addresses.
   always_ff @(posedge clk) begin
      if (reset) begin
         legacy_q <= 1'b0;
         qsize_q <= drcs_pkg::QSIZE_RST;
         desc_q <= 32'h0;
         avail_q <= 32'h0;
         used_q <= 32'h0;
         stage_a_q <= 32'h0;
         stage_l_q <= 32'h0;
         cfgo_q <= 32'h0;
         cfgs_q <= 32'h0;
         feat_q <= 32'h0;
      end else begin
         avail_q <= avail_d;
         used_q <= used_d;
         if (reg_wr) begin
            case (reg_addr)
               drcs_pkg::REG_CTRL: legacy_q <= reg_wdata[drcs_pkg::CTRL_LEGACY];
               drcs_pkg::REG_QSIZE: qsize_q <= reg_wdata[15:0];
               drcs_pkg::REG_DESC: desc_q <= {reg_wdata[31:4], 4'h0}; // [RULE_11]
               drcs_pkg::REG_SEGA: stage_a_q <= reg_wdata;
               drcs_pkg::REG_SEGL: stage_l_q <= reg_wdata;
               drcs_pkg::REG_CFGO: cfgo_q <= reg_wdata;
               drcs_pkg::REG_CFGS: cfgs_q <= reg_wdata;
               drcs_pkg::REG_FEAT: feat_q <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // Segment list for the next chain. Any split into at most MAX_SEG segments is allowed, but a readable
   // segment after a writable one is refused so the chain stays well ordered.
   always_ff @(posedge clk) begin
      if (reset) begin
         nseg_q <= '0;
         segw_q <= '0;
      end else if (st_q == drcs_pkg::ST_NOTE) begin
         nseg_q <= '0;
      end else if (reg_wr && (reg_addr == drcs_pkg::REG_SEGP) && (st_q == drcs_pkg::ST_IDLE) &&
                   (nseg_q < (SW+1)'(MAX_SEG)) && !err_set[drcs_pkg::ERR_ORDER]) begin // [RULE_16] [RULE_19]
         sega_q[nseg_q[SW-1:0]] <= stage_a_q;
         segl_q[nseg_q[SW-1:0]] <= stage_l_q;
         segw_q[nseg_q[SW-1:0]] <= reg_wdata[0];
         nseg_q <= nseg_q + 1'b1;
      end
   end

   // Sticky errors; a new error wins over a clear in the same cycle.
   always_ff @(posedge clk) begin
      if (reset) begin
         err_q <= '0;
      end else begin
         err_q <= (err_q & ~{5{cmd && reg_wdata[drcs_pkg::CTRL_CLRERR]}}) | err_set;
      end
   end

   // Register read port, data in the cycle after the strobe.
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            drcs_pkg::REG_CTRL: reg_rdata <= {31'h0, legacy_q};
            drcs_pkg::REG_QSIZE: reg_rdata <= {16'h0, qsize_q};
            drcs_pkg::REG_DESC: reg_rdata <= desc_q;
            drcs_pkg::REG_AVAIL: reg_rdata <= avail_q;
            drcs_pkg::REG_USED: reg_rdata <= used_q;
            drcs_pkg::REG_SEGA: reg_rdata <= stage_a_q;
            drcs_pkg::REG_SEGL: reg_rdata <= stage_l_q;
            drcs_pkg::REG_SEGP: reg_rdata <= {29'h0, 3'(nseg_q)};
            drcs_pkg::REG_CFGO: reg_rdata <= cfgo_q;
            drcs_pkg::REG_CFGS: reg_rdata <= cfgs_q;
            drcs_pkg::REG_FEAT: reg_rdata <= feat_q;
            drcs_pkg::REG_CFG0: reg_rdata <= cfg0_q;
            drcs_pkg::REG_CFG1: reg_rdata <= cfg1_q;
            drcs_pkg::REG_STAT: reg_rdata <= {out_q, 9'h0, cdone_q, err_q, st_q != drcs_pkg::ST_IDLE};
            drcs_pkg::REG_UID: reg_rdata <= uid_q;
            drcs_pkg::REG_ULEN: reg_rdata <= ulen_q;
            default: reg_rdata <= 32'h0;
         endcase
      end
   end

   // Sequencer: memory and config accesses go out one at a time and the
   // machine parks in a wait state until acknowledged, then resumes at ret_q.
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= drcs_pkg::ST_IDLE;
         ret_q <= drcs_pkg::ST_IDLE;
         mem <= '0;
         cfg <= '0;
         notify <= 1'b0;
         {rd_q, uid_q, ulen_q, gena_q, genb_q} <= '0;
         {d0_q, d1_q, p0_q, p1_q, cfg0_q, cfg1_q} <= '0;
         {k_q, w_q, cur_q, head_q, slot_q, aidx_q, lused_q, out_q, inuse_q} <= '0;
         {csel_q, have_q, cdone_q, poll_q} <= '0;
      end else begin
         notify <= 1'b0;
         // A completion signal is held until the idle machine takes it.
         poll_q <= (poll_q && !(st_q == drcs_pkg::ST_IDLE && !go_sub && !go_cfg)) || used_irq; // [RULE_14]
         case (st_q)
            drcs_pkg::ST_IDLE: begin
               if (go_sub && sub_ok) begin
                  k_q <= '0;
                  w_q <= 2'd0;
                  cur_q <= slot_q;
                  head_q <= slot_q;
                  st_q <= drcs_pkg::ST_DESC;
               end else if (go_cfg && cfg_chk) begin
                  // No features-accepted gate: config is readable from the start.
                  cdone_q <= 1'b0; // [RULE_06] [RULE_22]
                  have_q <= 1'b0;
                  st_q <= legacy_q ? drcs_pkg::ST_CD0 : drcs_pkg::ST_CGEN0;
               end else if (go_poll && !go_sub && !go_cfg) begin
                  st_q <= drcs_pkg::ST_UIDX;
               end
            end
            drcs_pkg::ST_DESC: begin
               // Four words per 16-byte entry: addr low, addr high (high first for a big-endian guest), len, flags/next.
               mem <= '{1'b1, 1'b1, 1'b0, desc_q + {12'h0, cur_q, 4'h0} + {28'h0, w_q, 2'b00},
                        fix(dword, w_q == 2'd3, be)}; // [RULE_10] [RULE_21]
               w_q <= w_q + 2'd1;
               ret_q <= drcs_pkg::ST_DESC;
               if (w_q == 2'd3) begin
                  k_q <= k_q + 1'b1;
                  cur_q <= (cur_q + 16'h0001) & qm;
                  if (k_q == nseg_q - 1'b1) begin
                     ret_q <= drcs_pkg::ST_AVENT;
                  end
               end
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_AVENT: begin
               mem <= '{1'b1, 1'b1, 1'b1,
                        avail_q + drcs_pkg::RING_ENT_OFS + {15'h0, aidx_q & qm, 1'b0},
                        fix({16'h0, head_q}, 1'b1, be)}; // [RULE_13]
               ret_q <= drcs_pkg::ST_AVIDX;
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_AVIDX: begin
               mem <= '{1'b1, 1'b1, 1'b1, avail_q + drcs_pkg::RING_IDX_OFS,
                        fix({16'h0, aidx_q + 16'h0001}, 1'b1, be)}; // [RULE_13]
               aidx_q <= aidx_q + 16'h0001;
               ret_q <= drcs_pkg::ST_NOTE;
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_NOTE: begin
               // Notify only after the head and the index have both landed.
               notify <= 1'b1; // [RULE_13]
               out_q <= out_q + 16'h0001; // [RULE_09]
               inuse_q <= inuse_q + 16'(nseg_q);
               chain_mem[head_q[TRK_W-1:0]] <= 8'(nseg_q);
               slot_q <= cur_q;
               st_q <= drcs_pkg::ST_IDLE;
            end
            drcs_pkg::ST_UIDX: begin
               mem <= '{1'b1, 1'b0, 1'b1, used_q + drcs_pkg::RING_IDX_OFS, 32'h0};
               ret_q <= drcs_pkg::ST_UCHK;
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_UCHK: begin
               st_q <= (rd_q[15:0] != lused_q) ? drcs_pkg::ST_UID : drcs_pkg::ST_IDLE; // [RULE_14]
            end
            drcs_pkg::ST_UID: begin
               mem <= '{1'b1, 1'b0, 1'b0,
                        used_q + drcs_pkg::RING_ENT_OFS + {13'h0, lused_q & qm, 3'b000}, 32'h0};
               ret_q <= drcs_pkg::ST_ULEN;
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_ULEN: begin
               uid_q <= rd_q;
               mem <= '{1'b1, 1'b0, 1'b0,
                        used_q + drcs_pkg::RING_ENT_OFS + {13'h0, lused_q & qm, 3'b100}, 32'h0};
               ret_q <= drcs_pkg::ST_UDONE;
               st_q <= drcs_pkg::ST_MWAIT;
            end
            drcs_pkg::ST_UDONE: begin
               // Chain lengths are tracked by the low head bits only, which
               // caps exact freeing at 2**TRK_W distinct heads.
               ulen_q <= rd_q;
               out_q <= out_q - 16'h0001;
               inuse_q <= inuse_q - {8'h0, chain_mem[uid_q[TRK_W-1:0]]};
               lused_q <= lused_q + 16'h0001;
               st_q <= drcs_pkg::ST_UIDX;
            end
            drcs_pkg::ST_CGEN0, drcs_pkg::ST_CGEN1: begin
               cfg <= '{1'b1, 1'b1, 16'h0};
               csel_q <= (st_q == drcs_pkg::ST_CGEN0) ? 2'd0 : 2'd3;
               ret_q <= (st_q == drcs_pkg::ST_CGEN0) ? drcs_pkg::ST_CD0 : drcs_pkg::ST_CCHK;
               st_q <= drcs_pkg::ST_CWAIT;
            end
            drcs_pkg::ST_CD0, drcs_pkg::ST_CD1: begin
               cfg <= '{1'b1, 1'b0, cfgo_q[15:0] + ((st_q == drcs_pkg::ST_CD1) ? 16'h4 : 16'h0)};
               csel_q <= (st_q == drcs_pkg::ST_CD0) ? 2'd1 : 2'd2;
               if (st_q == drcs_pkg::ST_CD0 && cfgo_q[drcs_pkg::CFGO_WIDE]) begin
                  ret_q <= drcs_pkg::ST_CD1;
               end else begin
                  ret_q <= legacy_q ? drcs_pkg::ST_CCHK : drcs_pkg::ST_CGEN1;
               end
               st_q <= drcs_pkg::ST_CWAIT;
            end
            drcs_pkg::ST_CCHK: begin
               if (!legacy_q) begin
                  // A changed generation means the words may be torn.
                  st_q <= (gena_q == genb_q) ? drcs_pkg::ST_IDLE : drcs_pkg::ST_CGEN0; // [RULE_02] [RULE_03]
                  cdone_q <= (gena_q == genb_q);
               end else begin
                  // No generation: two identical passes in a row are needed.
                  st_q <= (have_q && d0_q == p0_q && d1_q == p1_q) ?
                          drcs_pkg::ST_IDLE : drcs_pkg::ST_CD0; // [RULE_20]
                  cdone_q <= (have_q && d0_q == p0_q && d1_q == p1_q);
                  have_q <= 1'b1;
                  p0_q <= d0_q;
                  p1_q <= d1_q;
               end
               cfg0_q <= d0_q;
               cfg1_q <= d1_q;
            end
            drcs_pkg::ST_MWAIT: begin
               if (mem_ack) begin
                  mem.req <= 1'b0;
                  rd_q <= fix(mem_rdata, mem.half, be); // [RULE_18]
                  st_q <= ret_q;
               end
            end
            drcs_pkg::ST_CWAIT: begin
               if (cfg_ack) begin
                  cfg.rd <= 1'b0;
                  case (csel_q)
                     2'd0: gena_q <= cfg_rdata;
                     2'd1: d0_q <= fix(cfg_rdata, 1'b0, be); // [RULE_01]
                     2'd2: d1_q <= fix(cfg_rdata, 1'b0, be);
                     default: genb_q <= cfg_rdata;
                  endcase
                  st_q <= ret_q;
               end
            end
            default: st_q <= drcs_pkg::ST_IDLE;
         endcase
      end
   end

   // Checks on the sequencer and layout.
   notify_order_a: assert property (@(posedge clk) disable iff (reset) // [RULE_13]
      $rose(notify) |-> $past(st_q, 1) == drcs_pkg::ST_NOTE && $past(st_q, 3) == drcs_pkg::ST_MWAIT)
      else $error("notify without preceding ring update");
   qsize_legal_a: assert property (@(posedge clk) disable iff (reset) // [RULE_08]
      st_q == drcs_pkg::ST_DESC |-> q_ok)
      else $error("chain written with illegal queue size");
   outstanding_cap_a: assert property (@(posedge clk) disable iff (reset) // [RULE_09]
      st_q == drcs_pkg::ST_NOTE |-> out_q < qsize_q)
      else $error("outstanding buffers exceed queue size");
   ring_align_a: assert property (@(posedge clk) disable iff (reset) // [RULE_11]
      $stable(desc_q) && $stable(qsize_q) |=> desc_q[3:0] == 4'h0 && !avail_q[0] && used_q[1:0] == 2'b00)
      else $error("queue part misaligned");
   avail_place_a: assert property (@(posedge clk) disable iff (reset) // [RULE_12]
      $stable(desc_q) && $stable(qsize_q) |=> avail_q == $past(desc_q) + {12'h0, $past(qsize_q), 4'h0} &&
      used_q >= avail_q + 32'h6 + {15'h0, $past(qsize_q), 1'b0})
      else $error("ring placement does not follow sizes");
   legacy_page_a: assert property (@(posedge clk) disable iff (reset) // [RULE_17]
      legacy_q && $stable(legacy_q) && $stable(desc_q) && $stable(qsize_q) |=> used_q[11:0] == 12'h000)
      else $error("legacy used ring not page aligned");
   gen_retry_a: assert property (@(posedge clk) disable iff (reset) // [RULE_03]
      st_q == drcs_pkg::ST_CCHK && !legacy_q && gena_q != genb_q |=> st_q == drcs_pkg::ST_CGEN0 ##0 !cdone_q)
      else $error("config accepted across generation change");
   seg_order_a: assert property (@(posedge clk) disable iff (reset) // [RULE_16]
      st_q == drcs_pkg::ST_DESC && segw_q[0] && nseg_q > 1 |-> segw_q[1])
      else $error("readable segment after writable one");
   feat_gate_a: assert property (@(posedge clk) disable iff (reset) // [RULE_04]
      $rose(cfg.rd) && $past(st_q) == drcs_pkg::ST_CGEN0 |-> $past(cfg_chk, 2) || $past(cfg_chk, 3) || !cfgo_q[drcs_pkg::CFGO_OPT])
      else $error("optional field read without feature");

endmodule

`default_nettype wire

// ### sim/drcs_dev.sv
/*
 Device model: acks shared memory and config reads, reports completions.
 Assumes the controller holds each request until the cycle after its ack.
*/
`timescale 1ns/10ps
`default_nettype none
module drcs_dev (
   input wire logic clk,
   input wire logic reset,
   input wire drcs_pkg::drcs_mem_t mem,
   output logic mem_ack,
   output logic [31:0] mem_rdata,
   input wire drcs_pkg::drcs_cfg_t cfg,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   output logic used_irq,
   input wire logic notify
);
   logic [15:0] done_q;
   logic [31:0] gen_q, hw_q;
   // Acks last one cycle; idle data lines read back inverted so stale values never match.
   always_ff @(posedge clk) begin
      mem_ack <= !reset && mem.req && !mem_ack;
      cfg_ack <= !reset && cfg.rd && !cfg_ack;
      mem_rdata <= (mem.req && !mem_ack) ? {16'h0, mem.half ? done_q : hw_q[31:16]} : ~mem_rdata;
      cfg_rdata <= (cfg.rd && !cfg_ack) ? (cfg.gen ? gen_q : {cfg.addr, ~cfg.addr}) : ~cfg_rdata;
   end
   // Generation moves once during the first data read, forcing one retry.
   always_ff @(posedge clk) begin
      gen_q <= reset ? 32'h0 : gen_q + 32'(cfg.rd && !cfg.gen && gen_q == 32'h0);
   end
   // Each notify completes one buffer: used index advances and the interrupt pulses in the same cycle.
   always_ff @(posedge clk) begin
      done_q <= reset ? 16'h0 : done_q + 16'(notify);
      used_irq <= !reset && notify;
      // The ring entry write comes before the index write, so the older half-word is the chain head.
      if (mem.req && mem.we && mem.half && !mem_ack) begin
         hw_q <= {hw_q[15:0], mem.wdata[15:0]};
      end
   end
endmodule
`default_nettype wire

// ### sim/tb.sv
/*
 Self-checking bench of the ring controller against the device model.
 Assumes the register map and timing of the controller's package.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk, reset, reg_wr, reg_rd, mem_ack, cfg_ack, notify, used_irq, rd_d;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, mem_rdata, cfg_rdata;
   drcs_pkg::drcs_mem_t mem;
   drcs_pkg::drcs_cfg_t cfg;
   logic [31:0] exp_q[$];
   int err_total = 0, n_checks = 0, n_note = 0;
   drcs_host DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cfg(cfg),
      .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .notify(notify), .used_irq(used_irq));
   drcs_dev dev (.clk(clk), .reset(reset), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cfg(cfg),
      .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .used_irq(used_irq), .notify(notify));
   // Clock of 5 ns.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // An extra edge after each strobe keeps a driver from setting one signal twice per step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk) reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk) reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   // Read data appear in the cycle after the strobe; compare against the oldest note.
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (notify === 1'b1) n_note++;
      if (rd_d === 1'b1) begin
         n_checks++;
         if (reg_rdata !== exp_q[0]) begin
            err_total++;
            $display("[ERR] %0t read %h expected %h", $time, reg_rdata, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end
   // Hang guard.
   initial begin
      #20000;
      err_total++;
      tally_and_finish;
   end
   // Main sequence.
   initial begin
      void'($urandom(32'h6c75));
      reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(drcs_pkg::REG_QSIZE, 32'h100);
      rd(8'h40, 32'h0);
      wr(drcs_pkg::REG_QSIZE, 32'h6);
      wr(drcs_pkg::REG_CTRL, 32'h2);
      repeat (4) @(posedge clk);
      rd(drcs_pkg::REG_STAT, 32'h2);
      wr(drcs_pkg::REG_CTRL, 32'h10);
      wr(drcs_pkg::REG_QSIZE, 32'h8);
      wr(drcs_pkg::REG_DESC, 32'h1000);
      rd(drcs_pkg::REG_AVAIL, 32'h1080);
      rd(drcs_pkg::REG_USED, 32'h1098);
      wr(drcs_pkg::REG_SEGA, 32'h2000);
      wr(drcs_pkg::REG_SEGL, $urandom & 32'hffff);
      wr(drcs_pkg::REG_SEGP, 32'h0);
      wr(drcs_pkg::REG_CTRL, 32'h2);
      repeat (150) @(posedge clk);
      rd(drcs_pkg::REG_STAT, 32'h0);
      rd(drcs_pkg::REG_UID, 32'h0);
      n_checks++;
      if (n_note !== 1) begin
         err_total++;
         $display("[ERR] %0t notify count %0d", $time, n_note);
      end
      wr(drcs_pkg::REG_CFGS, 32'h40);
      wr(drcs_pkg::REG_CFGO, 32'h10);
      wr(drcs_pkg::REG_CTRL, 32'h4);
      repeat (100) @(posedge clk);
      rd(drcs_pkg::REG_CFG0, 32'h0010ffef);
      rd(drcs_pkg::REG_STAT, 32'h40);
      // Refused requests: readable after writable, optional field not offered, config too small.
      wr(drcs_pkg::REG_SEGP, 32'h1);
      wr(drcs_pkg::REG_SEGP, 32'h0);
      rd(drcs_pkg::REG_SEGP, 32'h1);
      wr(drcs_pkg::REG_CFGO, 32'h8500_0010);
      wr(drcs_pkg::REG_CTRL, 32'h4);
      wr(drcs_pkg::REG_CFGO, 32'h0001_003c);
      wr(drcs_pkg::REG_CTRL, 32'h4);
      rd(drcs_pkg::REG_STAT, 32'h74);
      // Legacy layout and a legacy config read with no generation counter.
      wr(drcs_pkg::REG_CFGO, 32'h20);
      wr(drcs_pkg::REG_CTRL, 32'h11);
      wr(drcs_pkg::REG_CTRL, 32'h5);
      rd(drcs_pkg::REG_USED, 32'h2000);
      repeat (40) @(posedge clk);
      rd(drcs_pkg::REG_CFG0, 32'h0020ffdf);
      rd(drcs_pkg::REG_STAT, 32'h40);
      tally_and_finish;
   end
endmodule
`default_nettype wire
